// [cpi_top.sv]
// crosspoint programming interface: pin sampling, ranks and routing
`timescale 1ns/1ps
`include "cpi_map.svh"
module cpi_top #(
   parameter int NUM_OUT = `CPI_NUM_OUT,
   parameter int NUM_IN  = `CPI_NUM_IN,
   parameter int FIELD_W = `CPI_FIELD_W
) (
   input  wire logic                       clk_sys,                // clock
   input  wire logic                       arst_n,                 // reset
   input  wire logic                       cs_n,                   // select
   input  wire logic                       serial_clk_n,           // sclk
   input  wire logic                       serial_data_in,         // sdi
   input  wire logic                       update_n,               // update
   input  wire logic                       serial_parallel_select, // mode
   input  wire logic                       write_strobe_n,         // we
   input  wire logic                       matrix_reset_n,         // rst
   input  wire logic                       cm_passthrough_select,  // cm
   input  wire logic [`CPI_ADDR_W-1:0]     output_channel_address, // addr
   input  wire logic                       output_enable_bit,      // d4
   input  wire logic [`CPI_SEL_W-1:0]      input_channel_select,   // d3..0
   output logic                            serial_data_out,        // sdo
   output logic [NUM_OUT-1:0]              out_enable,             // on
   output logic [NUM_OUT*`CPI_SEL_W-1:0]   out_select,             // sel
   output logic [NUM_OUT*NUM_IN-1:0]       route_onehot,           // x
   output logic                            cm_pass,                // cm
   output logic [1:0]                      prog_mode,              // mode
   output logic [`CPI_CNT_W-1:0]           shift_count,            // bits
   output logic                            word_loaded             // full
);
   localparam int WORD_W = NUM_OUT * FIELD_W;
   localparam int SEL_W  = `CPI_SEL_W;

   if (WORD_W != `CPI_WORD_W || FIELD_W != SEL_W + 1 ||
       NUM_IN != (1 << SEL_W) || NUM_OUT > (1 << `CPI_ADDR_W))
   begin : g_bad
      $error("crosspoint geometry not supported");
   end

   // field of output k from a full word
   function automatic logic [FIELD_W-1:0] field_of(
      input logic [WORD_W-1:0] w,
      input int                k
   );
      field_of = w[k*FIELD_W +: FIELD_W];
   endfunction

   // one-hot input choice, none when off
   function automatic logic [NUM_IN-1:0] route_of(
      input logic [FIELD_W-1:0] f
   );
      logic [NUM_IN-1:0] r;
      r = '0;
      if (f[`CPI_EN_POS])
         r[f[SEL_W-1:0]] = 1'b1;
      route_of = r;
   endfunction

   // reset release
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // all pins pass two flops before use
   logic [`CPI_PIN_W-1:0] pins_s;

   cpi_sync #(
      .W       (`CPI_PIN_W),
      .RST_VAL (`CPI_PIN_RST)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_q),
      .d       ({cs_n, serial_clk_n, serial_data_in, update_n,
                 serial_parallel_select, write_strobe_n, matrix_reset_n,
                 cm_passthrough_select, output_channel_address,
                 output_enable_bit, input_channel_select}),
      .q       (pins_s)
   );

   logic                   cs_n_s;
   logic                   sclk_n_s;
   logic                   sdi_s;
   logic                   upd_n_s;
   logic                   sp_s;
   logic                   we_n_s;
   logic                   mrst_n_s;
   logic                   cm_s;
   logic [`CPI_ADDR_W-1:0] addr_s;
   logic [FIELD_W-1:0]     data_s;

   assign {cs_n_s, sclk_n_s, sdi_s, upd_n_s, sp_s, we_n_s, mrst_n_s,
           cm_s, addr_s, data_s} = pins_s;

   logic gclk_n;
   logic gupd_n;

   assign gclk_n = sclk_n_s | cs_n_s;
   assign gupd_n = upd_n_s | cs_n_s;

   // edge history
   logic gclk_prev_q;
   logic we_prev_q;

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         gclk_prev_q <= 1'b1;
         we_prev_q   <= 1'b1;
      end
      else
      begin
         gclk_prev_q <= gclk_n;
         we_prev_q   <= we_n_s;
      end
   end

   logic gclk_fall;
   logic we_fall;

   assign gclk_fall = gclk_prev_q & ~gclk_n;
   assign we_fall   = we_prev_q & ~we_n_s;

   // first rank operation decode
   cpi_rank_if rif ();

   always_comb
   begin
      rif.op = cpi_pkg::op_none;
      if (!sp_s)
      begin
         if (gclk_fall)
            rif.op = cpi_pkg::op_shift;
         else if (we_fall && gclk_n)
            rif.op = cpi_pkg::op_bcast;
      end
      // parallel field write, select not needed
      else if (we_fall)
         rif.op = cpi_pkg::op_field;
   end

   assign rif.sdi  = sdi_s;
   assign rif.addr = addr_s;
   assign rif.data = data_s;

   // both programming paths share one register
   cpi_first_rank #(
      .NUM_OUT (NUM_OUT),
      .FIELD_W (FIELD_W)
   ) u_rank1 (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_q),
      .rif     (rif.rank)
   );

   // second rank; one clock behind the first rank while open
   logic [WORD_W-1:0] rank2_q;

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         rank2_q <= `CPI_RANK2_RST;
      // matrix reset clears only this rank
      else if (!mrst_n_s)
         rank2_q <= `CPI_RANK2_RST;
      else if (!gupd_n)
         rank2_q <= rif.word;
   end

   // fields split out here: a function result cannot be part-selected
   logic [FIELD_W-1:0] fld [NUM_OUT];

   always_comb
   begin
      for (int k = 0; k < NUM_OUT; k++)
         fld[k] = field_of(rank2_q, k);
   end

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         out_enable   <= '0;
         out_select   <= '0;
         route_onehot <= '0;
      end
      else
      begin
         for (int k = 0; k < NUM_OUT; k++)
         begin
            out_enable[k] <= fld[k][`CPI_EN_POS];
            out_select[k*SEL_W +: SEL_W] <= fld[k][SEL_W-1:0];
            route_onehot[k*NUM_IN +: NUM_IN] <= route_of(fld[k]);
         end
      end
   end

   // last stage feeds the next device
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         serial_data_out <= 1'b0;
      else
         serial_data_out <= rif.word[WORD_W-1];
   end

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         cm_pass <= 1'b0;
      else
         cm_pass <= cm_s;
   end

   // mode status for software visibility
   cpi_pkg::cpi_mode_t mode_d;

   always_comb
   begin
      case ({sp_s, cs_n_s, gclk_n})
         3'h0, 3'h1:
            mode_d = cpi_pkg::mode_serial;
         3'h2, 3'h3:
            mode_d = cpi_pkg::mode_broadcast;
         3'h4, 3'h5, 3'h6, 3'h7:
            mode_d = cpi_pkg::mode_parallel;
         default:
            mode_d = cpi_pkg::mode_idle;
      endcase
      if (!sp_s && cs_n_s)
         mode_d = cpi_pkg::mode_idle;
   end

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         prog_mode <= cpi_pkg::mode_idle;
      else
         prog_mode <= mode_d;
   end

   // count bits of one word; wraps every 45
   logic shifting;

   assign shifting = (rif.op == cpi_pkg::op_shift);

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         shift_count <= '0;
      else if (shifting)
      begin
         if (shift_count == `CPI_CNT_LAST)
            shift_count <= '0;
         else
            shift_count <= shift_count + 1'b1;
      end
      else if (cs_n_s)
         shift_count <= '0;
   end

   // full word ready to apply; a new shift starts over
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         word_loaded <= 1'b0;
      else if (shifting)
         word_loaded <= (shift_count == `CPI_CNT_LAST);
      else if (rif.op == cpi_pkg::op_bcast)
         word_loaded <= 1'b1;
   end
endmodule

// [cpi_map.svh]
// constants for the crosspoint programming interface
`ifndef CPI_MAP_SVH
`define CPI_MAP_SVH
`define CPI_NUM_OUT      9
`define CPI_NUM_IN       16
`define CPI_FIELD_W      5
`define CPI_WORD_W       45
`define CPI_EN_POS       4
`define CPI_SEL_W        4
`define CPI_ADDR_W       4
`define CPI_CNT_W        6
`define CPI_CNT_LAST     6'h2c
`define CPI_PIN_W        17
`define CPI_PIN_RST      17'h1ffff
`define CPI_RANK1_RST    45'h0
`define CPI_RANK2_RST    45'h0
`endif

// [cpi_pkg.sv]
// types shared by the crosspoint programming modules
`include "cpi_map.svh"
package cpi_pkg;
   typedef enum logic [1:0] {
      mode_idle,
      mode_serial,
      mode_parallel,
      mode_broadcast
   } cpi_mode_t;
   typedef enum logic [1:0] {
      op_none,
      op_shift,
      op_field,
      op_bcast
   } cpi_op_t;
   typedef logic [`CPI_FIELD_W-1:0] cpi_field_t;
endpackage

// [cpi_rank_if.sv]
// link between the control logic and the first-rank register
`timescale 1ns/1ps
`include "cpi_map.svh"
interface cpi_rank_if;
   cpi_pkg::cpi_op_t          op;
   logic                      sdi;
   logic [`CPI_ADDR_W-1:0]    addr;
   cpi_pkg::cpi_field_t       data;
   logic [`CPI_WORD_W-1:0]    word;
   modport ctrl (output op, output sdi, output addr, output data,
                 input word);
   modport rank (input op, input sdi, input addr, input data,
                 output word);
endinterface

// [cpi_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`include "cpi_map.svh"
module cpi_sync #(
   parameter int         W       = `CPI_PIN_W,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic          clk_sys,  // system clock
   input  wire logic          rst_n,    // synchronised reset
   input  wire logic [W-1:0]  d,        // asynchronous pins
   output logic      [W-1:0]  q         // synchronised copy
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// [cpi_first_rank.sv]
// first-rank programming register: serial shift, field and broadcast
`timescale 1ns/1ps
`include "cpi_map.svh"
module cpi_first_rank #(
   parameter int NUM_OUT = `CPI_NUM_OUT,
   parameter int FIELD_W = `CPI_FIELD_W
) (
   input  wire logic  clk_sys,  // system clock
   input  wire logic  rst_n,    // synchronised reset
   cpi_rank_if.rank   rif       // operation in, word out
);
   localparam int WORD_W = NUM_OUT * FIELD_W;

   if (WORD_W != `CPI_WORD_W || FIELD_W != `CPI_FIELD_W)
   begin : g_bad
      $error("first rank size does not match the interface");
   end

   logic [WORD_W-1:0] word_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         word_q <= `CPI_RANK1_RST;
      else
      begin
         case (rif.op)
            cpi_pkg::op_shift:
               word_q <= {word_q[WORD_W-2:0], rif.sdi};
            cpi_pkg::op_field:
               if (int'(rif.addr) < NUM_OUT)
                  word_q[int'(rif.addr)*FIELD_W +: FIELD_W] <= rif.data;
            cpi_pkg::op_bcast:
               word_q <= {NUM_OUT{rif.data}};
            default:
               word_q <= word_q;
         endcase
      end
   end

   assign rif.word = word_q;
endmodule

// [cpi_checker.sv]
// assertions on the crosspoint programming ports
`timescale 1ns/1ps
`include "cpi_map.svh"
module cpi_checker #(
   parameter int NUM_OUT = 9,
   parameter int NUM_IN  = 16
) (
   input logic                          clk_sys,               // clk
   input logic                          arst_n,                // rst
   input logic                          cs_n,                  // select
   input logic                          serial_parallel_select, // mode
   input logic                          serial_clk_n,          // sclk
   input logic                          write_strobe_n,        // we
   input logic                          matrix_reset_n,        // clear
   input logic                          cm_passthrough_select, // cm
   input logic                          serial_data_out,       // sdo
   input logic [NUM_OUT-1:0]            out_enable,            // on
   input logic [NUM_OUT*`CPI_SEL_W-1:0] out_select,            // sel
   input logic [NUM_OUT*NUM_IN-1:0]     route_onehot,          // x
   input logic                          cm_pass,               // cm
   input logic [`CPI_CNT_W-1:0]         shift_count            // bits
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // select stable, serial clock and write strobe held high long enough for the pipeline to drain
   sequence s_quiet;
      ($stable(cs_n) && serial_clk_n && write_strobe_n) [*8];
   endsequence
   sequence s_desel;
      (cs_n && matrix_reset_n) [*8];
   endsequence
   for (genvar k = 0; k < NUM_OUT; k++)
   begin : g_out
      a_route_onehot: assert property (
         route_onehot[k*NUM_IN +: NUM_IN] == (out_enable[k] ?
         NUM_IN'(1) << out_select[k*4 +: 4] : '0)) else $error("route");
   end
   a_clk_to_count: assert property (
      $fell(serial_clk_n) && !cs_n && !serial_parallel_select |->
      ##[2:4] $changed(shift_count))
      else $error("shift lost");
   a_desel_count: assert property (
      cs_n [*5] |-> shift_count == 0) else $error("count kept");
   a_update_gate: assert property (
      s_desel |-> $stable(out_enable) && $stable(out_select))
      else $error("update while deselected");
   a_reset_clears: assert property (
      !matrix_reset_n [*5] |-> out_enable == 0) else $error("reset");
   a_cm_follows: assert property (
      $stable(cm_passthrough_select) [*8] |->
      cm_pass == cm_passthrough_select) else $error("cm");
   a_pins_quiet: assert property (
      s_quiet |-> $stable(serial_data_out) && $stable(shift_count))
      else $error("moved without edge");
   a_count_step: assert property (
      $changed(shift_count) |-> shift_count == 0 ||
      shift_count == $past(shift_count) + 6'h01) else $error("count step");
endmodule

// [cpi_ctrl_model.sv]
// behavioural controller driving the programming pins
`timescale 1ns/1ps
module cpi_ctrl_model (
   input  logic       clk_sys, // clock
   output logic       cs_n,    // select
   output logic       sclk_n,  // serial clock
   output logic       sdi,     // serial data
   output logic       upd_n,   // update
   output logic       sps,     // mode
   output logic       we_n,    // strobe
   output logic [3:0] addr,    // output
   output logic       en,      // enable
   output logic [3:0] sel      // input
);
   initial
   begin
      cs_n = 1'b1;
      sclk_n = 1'b1;
      sdi = 1'b0;
      upd_n = 1'b1;
      sps = 1'b1;
      we_n = 1'b1;
      addr = 4'h0;
      en = 1'b0;
      sel = 4'h0;
   end
   // four clocks per level, one spare over the sampler's three
   task automatic hold();
      repeat (4) @(negedge clk_sys);
   endtask
   // select, then mode, then one bit
   task automatic shift_bit(input logic b);
      cs_n = 1'b0;
      hold();
      sps = 1'b0;
      sdi = b;
      hold();
      sclk_n = 1'b0;
      hold();
      sclk_n = 1'b1;
      // hold time over, the line no longer shows the bit
      sdi = ~b;
      hold();
   endtask
   // update pulse under a given select
   task automatic update(input logic c);
      cs_n = c;
      hold();
      upd_n = 1'b0;
      hold();
      upd_n = 1'b1;
      hold();
   endtask
   task automatic set_upd(input logic v);
      upd_n = v;
      hold();
   endtask
   // strobe write, one field or broadcast
   task automatic strobe(input logic p, input logic [3:0] a,
                         input logic e, input logic [3:0] s);
      sps = p;
      addr = a;
      en = e;
      sel = s;
      hold();
      we_n = 1'b0;
      hold();
      we_n = 1'b1;
      addr = ~a;
      en = ~e;
      sel = ~s;
      hold();
   endtask
endmodule

// [tb.sv]
// self-checking bench for the crosspoint programming interface
`timescale 1ns/1ps
`include "cpi_map.svh"
bind cpi_top cpi_checker #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN))
   u_cpi_checker (.clk_sys, .arst_n, .cs_n, .serial_clk_n, .write_strobe_n,
   .matrix_reset_n, .cm_passthrough_select, .serial_data_out, .out_enable,
   .out_select, .route_onehot, .cm_pass, .shift_count,
   .serial_parallel_select);
module tb;
   typedef struct packed {
      logic [44:0] w;
      logic [8:0]  on;
   } cpi_row_t;
   logic        clk_sys, arst_n, mrst_n, cm_sel, cmp, sdo;
   logic        cs_n, sclk_n, sdi, upd_n, sps, we_n, en, wl;
   logic [1:0]  mode;
   logic [143:0] rt;
   logic [3:0]  addr, sel;
   logic [8:0]  on;
   logic [35:0] osel;
   logic [5:0]  cnt;
   logic [44:0] prev, w;
   int          error_cnt = 0;
   int          cmp_count = 0;
   cpi_row_t    rows [5] = '{'{45'h0, 9'h0}, '{45'h108421084210, 9'h1ff},
      '{45'h0f7bdef7bdef, 9'h0}, '{45'h1fffffffffff, 9'h1ff},
      '{45'h18bdab49ca30, 9'h1ff}};
   cpi_top u_cpi_top (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n),
      .serial_clk_n(sclk_n), .serial_data_in(sdi), .update_n(upd_n),
      .serial_parallel_select(sps), .write_strobe_n(we_n),
      .matrix_reset_n(mrst_n), .cm_passthrough_select(cm_sel),
      .output_channel_address(addr), .output_enable_bit(en),
      .input_channel_select(sel), .serial_data_out(sdo), .out_enable(on),
      .out_select(osel), .route_onehot(rt), .cm_pass(cmp), .prog_mode(mode),
      .shift_count(cnt), .word_loaded(wl));
   cpi_ctrl_model u_cpi_ctrl_model (.clk_sys, .cs_n, .sclk_n, .sdi,
      .upd_n, .sps, .we_n, .addr, .en, .sel);
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [143:0] got, input logic [143:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // field k sits at bits 5k+4..5k, enable on top
   task automatic chk_word(input logic [44:0] v);
      logic [8:0]  e;
      logic [35:0] s;
      logic [143:0] r;
      r = '0;
      for (int k = 0; k < 9; k++)
      begin
         e[k] = v[5*k+4];
         s[4*k +: 4] = v[5*k +: 4];
         if (v[5*k+4])
            r[16*k + v[5*k +: 4]] = 1'b1;
      end
      chk(on, e);
      chk(osel, s);
      chk(rt, r);
   endtask
   // sdo shows the previous word bit by bit, as the next chip would see
   task automatic send(input logic [44:0] v);
      for (int j = 44; j >= 0; j--)
      begin
         chk(sdo, prev[j]);
         chk(cnt, 44 - j);
         if (j < 44)
            chk(wl, 0);
         u_cpi_ctrl_model.shift_bit(v[j]);
      end
      prev = v;
   endtask
   initial
   begin
      arst_n = 1'b0;
      mrst_n = 1'b1;
      cm_sel = 1'b0;
      prev = '0;
      repeat (3) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk(on, 0);
      chk(cnt, 0);
      chk(mode, 2'h2);
      foreach (rows[i])
      begin
         send(rows[i].w);
         chk(wl, 1);
         chk(mode, 2'h1);
         u_cpi_ctrl_model.update(1'b0);
         chk(cnt, 0);
         chk(on, rows[i].on);
         chk_word(rows[i].w);
      end
      w = prev;
      w[19:15] = 5'h1a;
      u_cpi_ctrl_model.strobe(1'b1, 4'h3, 1'b1, 4'ha);
      chk(mode, 2'h2);
      u_cpi_ctrl_model.update(1'b1);
      chk_word(prev);
      u_cpi_ctrl_model.strobe(1'b1, 4'h9, 1'b0, 4'h0);
      u_cpi_ctrl_model.update(1'b0);
      chk_word(w);
      w = {9{5'h15}};
      u_cpi_ctrl_model.strobe(1'b0, 4'h0, 1'b1, 4'h5);
      mrst_n = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk(on, 0);
      mrst_n = 1'b1;
      u_cpi_ctrl_model.update(1'b0);
      chk_word(w);
      u_cpi_ctrl_model.set_upd(1'b0);
      u_cpi_ctrl_model.shift_bit(1'b0);
      chk_word({w[43:0], 1'b0});
      chk(wl, 0);
      u_cpi_ctrl_model.set_upd(1'b1);
      cm_sel = 1'b1;
      repeat (12) @(negedge clk_sys);
      chk(cmp, 1);
      cm_sel = 1'b0;
      repeat (12) @(negedge clk_sys);
      chk(cmp, 0);
      test_done();
   end
   // run needs about 4000 clocks
   initial
   begin
      repeat (10000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
endmodule
